/* File: frr_pkg.sv */
// Shared constants and helpers for fixed-range memory/I/O routing
`default_nettype none
package frr_pkg;
	// Field storage
	localparam int         NFIELD        = 8;
	localparam int         IDX_W         = 3;
	localparam int         FLD_W         = 5;
	localparam int         WRITE_TO_MEMORY_BIT     = 3;
	localparam int         READ_TO_MEMORY_BIT     = 4;
	localparam logic [4:0] FLD_RESET     = 5'h00;
	// System configuration word
	localparam int         CFG_ATTR_BIT  = 18;
	localparam int         CFG_MOD_BIT   = 19;
	localparam logic [31:0] CFG_RESET    = 32'h0000_0000;
	// Memory-type encodings
	localparam logic [2:0] MT_UC         = 3'h0;
	localparam logic [2:0] MT_WC         = 3'h1;
	localparam logic [2:0] MT_WT         = 3'h4;
	localparam logic [2:0] MT_WP         = 3'h5;
	localparam logic [2:0] MT_WB         = 3'h6;
	// Controller register offsets
	localparam logic [11:0] REG_CMD      = 12'h000;
	localparam logic [11:0] REG_STATUS   = 12'h004;
	localparam logic [11:0] REG_DATA     = 12'h008;
	// Command word layout
	localparam int         CMD_IDX_LSB   = 8;
	localparam int         CMD_VAL_LSB   = 16;
	localparam int         CMD_WR_BIT    = 24;
	// Opcodes
	localparam logic [3:0] OP_MOD_ON     = 4'h1;
	localparam logic [3:0] OP_MOD_OFF    = 4'h2;
	localparam logic [3:0] OP_SET_FIELD  = 4'h3;
	localparam logic [3:0] OP_ENABLE     = 4'h4;
	localparam logic [3:0] OP_ACCESS     = 4'h5;
	localparam logic [3:0] OP_READ       = 4'h6;
	localparam logic [3:0] OP_SHADOW_CPY = 4'h7;
	localparam logic [3:0] OP_SHADOW_USE = 4'h8;
	localparam logic [3:0] OP_CHANGE     = 4'h9;
	// Status bits
	localparam int         ST_BUSY       = 0;
	localparam int         ST_REFUSED    = 1;
	localparam int         ST_TO_MEM     = 2;
	localparam int         ST_RESERVED   = 3;
	localparam int         ST_PRESENT    = 4;
	localparam int         ST_MOD_EN     = 5;
	localparam int         ST_ATTR_EN    = 6;

	// Legal pairing of routing bits and memory type
	function automatic logic frr_combo_ok(input logic [4:0] f);
		logic [2:0] t;
		t = f[2:0];
		case (f[READ_TO_MEMORY_BIT:WRITE_TO_MEMORY_BIT])
			2'b00:   frr_combo_ok = (t == MT_UC) || (t == MT_WC) || (t == MT_WT) || (t == MT_WP);
			2'b01:   frr_combo_ok = (t == MT_UC);
			2'b10:   frr_combo_ok = (t == MT_UC) || (t == MT_WP);
			default: frr_combo_ok = (t == MT_UC) || (t == MT_WC) || (t == MT_WT) || (t == MT_WB);
		endcase
	endfunction : frr_combo_ok

	function automatic logic frr_cacheable(input logic [2:0] t);
		frr_cacheable = (t == MT_WB) || (t == MT_WT) || (t == MT_WP);
	endfunction : frr_cacheable
endpackage : frr_pkg
`default_nettype wire

/* File: frr_link_if.sv */
// Link between the routing controller and the routing unit
`default_nettype none
interface frr_link_if
	import frr_pkg::*;
();
	logic              cfg_wr;
	logic [31:0]       cfg_wdata;
	logic [31:0]       cfg_rdata;
	logic              fld_wr;
	logic              fld_rd;
	logic [IDX_W-1:0]  fld_idx;
	logic [FLD_W-1:0]  fld_wdata;
	logic              fld_rvalid;
	logic [FLD_W-1:0]  fld_rdata;
	logic              acc_valid;
	logic [IDX_W-1:0]  acc_idx;
	logic              acc_write;
	logic              rsp_valid;
	logic              rsp_to_mem;
	logic [2:0]        rsp_type;
	logic              rsp_reserved;

	modport dev (
		input  cfg_wr, cfg_wdata, fld_wr, fld_rd, fld_idx, fld_wdata,
		input  acc_valid, acc_idx, acc_write,
		output cfg_rdata, fld_rvalid, fld_rdata,
		output rsp_valid, rsp_to_mem, rsp_type, rsp_reserved
	);
	modport host (
		output cfg_wr, cfg_wdata, fld_wr, fld_rd, fld_idx, fld_wdata,
		output acc_valid, acc_idx, acc_write,
		input  cfg_rdata, fld_rvalid, fld_rdata,
		input  rsp_valid, rsp_to_mem, rsp_type, rsp_reserved
	);
endinterface : frr_link_if
`default_nettype wire

/* File: frr_router.sv */
// Routing unit: fixed-range type fields, enables and memory/I-O steering
`default_nettype none
module frr_router
	import frr_pkg::*;
(
	// Clock and reset
	input  wire logic              pclk,
	input  wire logic              presetn,
	// Link from the controller
	frr_link_if.dev                lnk,
	// Routed access strobes
	output logic                   mem_rd,
	output logic                   mem_wr,
	output logic                   mmio_rd,
	output logic                   mmio_wr,
	output logic [2:0]             route_type,
	output logic                   route_reserved,
	// Configuration state
	output logic                   attr_en,
	output logic                   mod_en
);

	logic [31:0]      system_configuration_reg;
	logic [FLD_W-1:0] fld_reg [NFIELD];
	logic [FLD_W-1:0] acc_fld;
	logic [FLD_W-1:0] rd_fld;
	logic             acc_bit;
	logic             to_mem;
	logic             combo_ok;
	logic             rsp_valid_reg;
	logic             rsp_to_mem_reg;
	logic             rsp_write_reg;
	logic [2:0]       rsp_type_reg;
	logic             rsp_res_reg;
	logic             rvalid_reg;
	logic [FLD_W-1:0] rdata_reg;

	assign attr_en = system_configuration_reg[CFG_ATTR_BIT];
	assign mod_en  = system_configuration_reg[CFG_MOD_BIT];

	// System configuration word; bits outside the two enables are plain storage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			system_configuration_reg <= CFG_RESET;
		end else if (lnk.cfg_wr) begin
			system_configuration_reg <= lnk.cfg_wdata;
		end
	end

	assign lnk.cfg_rdata = system_configuration_reg;

	// One field store per fixed range
	for (genvar i = 0; i < NFIELD; i++) begin : g_fld
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				fld_reg[i] <= FLD_RESET;
			end else if (lnk.fld_wr && (lnk.fld_idx == IDX_W'(i))) begin
				fld_reg[i][2:0] <= lnk.fld_wdata[2:0];
				if (mod_en) begin
					fld_reg[i][READ_TO_MEMORY_BIT:WRITE_TO_MEMORY_BIT] <= lnk.fld_wdata[READ_TO_MEMORY_BIT:WRITE_TO_MEMORY_BIT];
				end
			end
		end
	end

	// Routing bits read back as zero while modification is locked
	always_comb begin
		rd_fld = fld_reg[lnk.fld_idx];
		if (!mod_en) begin
			rd_fld[READ_TO_MEMORY_BIT:WRITE_TO_MEMORY_BIT] = 2'b00;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rvalid_reg <= 1'b0;
			rdata_reg  <= FLD_RESET;
		end else begin
			rvalid_reg <= lnk.fld_rd;
			if (lnk.fld_rd) begin
				rdata_reg <= rd_fld;
			end
		end
	end

	assign lnk.fld_rvalid = rvalid_reg;
	assign lnk.fld_rdata  = rdata_reg;

	// Route decision for one access
	always_comb begin
		acc_fld = fld_reg[lnk.acc_idx];
		// Each direction looks only at its own routing bit
		acc_bit = lnk.acc_write ? acc_fld[WRITE_TO_MEMORY_BIT] : acc_fld[READ_TO_MEMORY_BIT];
		// Without the enable every access falls to I/O
		to_mem  = attr_en && acc_bit;
		combo_ok = frr_combo_ok(acc_fld);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rsp_valid_reg  <= 1'b0;
			rsp_to_mem_reg <= 1'b0;
			rsp_write_reg  <= 1'b0;
			rsp_type_reg   <= MT_UC;
			rsp_res_reg    <= 1'b0;
		end else begin
			rsp_valid_reg <= lnk.acc_valid;
			if (lnk.acc_valid) begin
				rsp_to_mem_reg <= to_mem;
				rsp_write_reg  <= lnk.acc_write;
				rsp_type_reg   <= acc_fld[2:0];
				// Reserved pairing only matters once routing is live
				rsp_res_reg    <= attr_en && !combo_ok;
			end
		end
	end

	assign lnk.rsp_valid    = rsp_valid_reg;
	assign lnk.rsp_to_mem   = rsp_to_mem_reg;
	assign lnk.rsp_type     = rsp_type_reg;
	assign lnk.rsp_reserved = rsp_res_reg;

	// Strobes toward the two targets
	assign mem_rd         = rsp_valid_reg && rsp_to_mem_reg && !rsp_write_reg;
	assign mem_wr         = rsp_valid_reg && rsp_to_mem_reg && rsp_write_reg;
	assign mmio_rd        = rsp_valid_reg && !rsp_to_mem_reg && !rsp_write_reg;
	assign mmio_wr        = rsp_valid_reg && !rsp_to_mem_reg && rsp_write_reg;
	assign route_type     = rsp_type_reg;
	assign route_reserved = rsp_res_reg;

endmodule : frr_router
`default_nettype wire

/* File: frr_ctrl.sv */
// Routing controller: APB command registers driving the routing unit
`default_nettype none
module frr_ctrl
	import frr_pkg::*;
(
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// Page mapping maintenance
	output logic             page_present,
	output logic             tlb_flush_req,
	input  wire logic        tlb_flush_ack,
	output logic             cache_flush_req,
	input  wire logic        cache_flush_ack,
	// Link to the routing unit
	frr_link_if.host         lnk
);

	typedef enum logic [2:0] {S_IDLE, S_ACC, S_RD, S_TLB, S_CACHE, S_MAP} frr_state_t;

	frr_state_t       state_reg;
	logic             mod_reg, attr_reg, refused_reg, to_mem_reg, res_reg;
	logic [NFIELD-1:0] init_reg;
	logic [FLD_W-1:0] mirror_reg [NFIELD];
	logic [FLD_W-1:0] data_reg, val_reg;
	logic [IDX_W-1:0] idx_reg;
	logic             cfg_wr_reg, fld_wr_reg, fld_rd_reg, acc_reg, accw_reg;
	logic [31:0]      cfg_data_reg;
	logic [3:0]       op;
	logic [IDX_W-1:0] c_idx;
	logic [FLD_W-1:0] c_val, chg_val;
	logic             wr_en, cmd_wr, refuse, busy;

	assign op     = pwdata[3:0];
	assign c_idx  = pwdata[CMD_IDX_LSB +: IDX_W];
	assign c_val  = pwdata[CMD_VAL_LSB +: FLD_W];
	assign busy   = (state_reg != S_IDLE) || cfg_wr_reg || fld_wr_reg;
	assign wr_en  = psel && penable && pwrite;
	assign cmd_wr = wr_en && (paddr[11:0] == REG_CMD) && !busy;
	assign pready = 1'b1;
	assign chg_val = {mirror_reg[c_idx][READ_TO_MEMORY_BIT:WRITE_TO_MEMORY_BIT], c_val[2:0]};

	always_comb begin
		case (op)
			OP_SET_FIELD:  refuse = !mod_reg || !frr_combo_ok(c_val);
			OP_ENABLE:     refuse = !mod_reg || !(&init_reg);
			OP_SHADOW_CPY: refuse = !mod_reg;
			OP_SHADOW_USE: refuse = !mod_reg;
			OP_CHANGE:     refuse = !frr_combo_ok(chg_val);
			default:       refuse = 1'b0;
		endcase
	end

	always_comb begin
		prdata  = 32'h0000_0000;
		pslverr = 1'b0;
		case (paddr[11:0])
			REG_CMD:    pslverr = psel && penable && pwrite && busy;
			REG_STATUS: prdata  = 32'({attr_reg, mod_reg, page_present, res_reg,
				to_mem_reg, refused_reg, busy});
			REG_DATA:   prdata  = 32'(data_reg);
			default:    pslverr = psel && penable;
		endcase
	end

	// Command sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= S_IDLE;
			{mod_reg, attr_reg, refused_reg, cfg_wr_reg, fld_wr_reg} <= 5'h00;
			{fld_rd_reg, acc_reg, accw_reg, to_mem_reg, res_reg} <= 5'h00;
			{page_present, tlb_flush_req, cache_flush_req} <= 3'h4;
			init_reg     <= '0;
			idx_reg      <= '0;
			val_reg      <= FLD_RESET;
			data_reg     <= FLD_RESET;
			cfg_data_reg <= CFG_RESET;
			for (int i = 0; i < NFIELD; i++) begin
				mirror_reg[i] <= FLD_RESET;
			end
		end else begin
			{cfg_wr_reg, fld_wr_reg, fld_rd_reg, acc_reg} <= 4'h0;
			if (fld_wr_reg) begin
				mirror_reg[idx_reg] <= val_reg;
				init_reg[idx_reg]   <= 1'b1;
			end
			case (state_reg)
				S_IDLE: if (cmd_wr) begin
					refused_reg <= refuse;
					idx_reg     <= c_idx;
					if (!refuse) begin
						case (op)
							OP_MOD_ON: begin
								mod_reg      <= 1'b1;
								init_reg     <= '0;
								cfg_wr_reg   <= 1'b1;
								cfg_data_reg <= (CFG_RESET | (32'h1 << CFG_MOD_BIT))
									| (32'(attr_reg) << CFG_ATTR_BIT);
							end
							OP_MOD_OFF: begin
								mod_reg      <= 1'b0;
								cfg_wr_reg   <= 1'b1;
								cfg_data_reg <= CFG_RESET | (32'(attr_reg) << CFG_ATTR_BIT);
							end
							OP_ENABLE: begin
								attr_reg     <= 1'b1;
								cfg_wr_reg   <= 1'b1;
								cfg_data_reg <= CFG_RESET | (32'h1 << CFG_MOD_BIT)
									| (32'h1 << CFG_ATTR_BIT);
							end
							OP_SET_FIELD: begin
								fld_wr_reg <= 1'b1;
								val_reg    <= c_val;
							end
							OP_SHADOW_CPY: begin
								fld_wr_reg <= 1'b1;
								val_reg    <= {2'b01, MT_UC};
							end
							OP_SHADOW_USE: begin
								fld_wr_reg <= 1'b1;
								val_reg    <= {2'b10, MT_UC};
							end
							OP_ACCESS: begin
								acc_reg   <= 1'b1;
								accw_reg  <= pwdata[CMD_WR_BIT];
								state_reg <= S_ACC;
							end
							OP_READ: begin
								fld_rd_reg <= 1'b1;
								state_reg  <= S_RD;
							end
							OP_CHANGE: begin
								val_reg       <= chg_val;
								page_present  <= 1'b0;
								tlb_flush_req <= 1'b1;
								state_reg     <= S_TLB;
							end
							default: refused_reg <= 1'b1;
						endcase
					end
				end
				S_ACC: if (lnk.rsp_valid) begin
					to_mem_reg <= lnk.rsp_to_mem;
					res_reg    <= lnk.rsp_reserved;
					data_reg   <= {2'b00, lnk.rsp_type};
					state_reg  <= S_IDLE;
				end
				S_RD: if (lnk.fld_rvalid) begin
					data_reg  <= lnk.fld_rdata;
					state_reg <= S_IDLE;
				end
				S_TLB: if (tlb_flush_ack) begin
					tlb_flush_req <= 1'b0;
					// Leaving a cacheable class needs a cache flush, only after the TLBs
					if (frr_cacheable(mirror_reg[idx_reg][2:0])
						&& !frr_cacheable(val_reg[2:0])) begin
						cache_flush_req <= 1'b1;
						state_reg       <= S_CACHE;
					end else begin
						state_reg <= S_MAP;
					end
				end
				S_CACHE: if (cache_flush_ack) begin
					cache_flush_req <= 1'b0;
					state_reg       <= S_MAP;
				end
				S_MAP: begin
					fld_wr_reg   <= 1'b1;
					page_present <= 1'b1;
					state_reg    <= S_IDLE;
				end
				default: state_reg <= S_IDLE;
			endcase
		end
	end

	assign lnk.cfg_wr    = cfg_wr_reg;
	assign lnk.cfg_wdata = cfg_data_reg;
	assign lnk.fld_wr    = fld_wr_reg;
	assign lnk.fld_rd    = fld_rd_reg;
	assign lnk.fld_idx   = idx_reg;
	assign lnk.fld_wdata = val_reg;
	assign lnk.acc_valid = acc_reg;
	assign lnk.acc_idx   = idx_reg;
	assign lnk.acc_write = accw_reg;

endmodule : frr_ctrl
`default_nettype wire

/* File: frr_link_assertions.sv */
// Checker for the link between routing controller and routing unit
`default_nettype none
module frr_link_assertions
	import frr_pkg::*;
(
	// Clock and reset
	input wire logic             pclk,
	input wire logic             presetn,
	// Link signals
	input wire logic             cfg_wr,
	input wire logic [31:0]      cfg_wdata,
	input wire logic [31:0]      cfg_rdata,
	input wire logic             fld_wr,
	input wire logic             fld_rd,
	input wire logic [IDX_W-1:0] fld_idx,
	input wire logic [FLD_W-1:0] fld_wdata,
	input wire logic             fld_rvalid,
	input wire logic [FLD_W-1:0] fld_rdata,
	input wire logic             acc_valid,
	input wire logic [IDX_W-1:0] acc_idx,
	input wire logic             acc_write,
	input wire logic             rsp_valid,
	input wire logic             rsp_to_mem,
	input wire logic [2:0]       rsp_type,
	input wire logic             rsp_reserved
);
	timeunit 1ns;
	timeprecision 100ps;
	// Own copy of the fields, built only from link writes
	logic [FLD_W-1:0] mir [NFIELD];
	logic             exp_mem;
	logic [2:0]       exp_type;
	logic [FLD_W-1:0] exp_rd;
	logic [1:0]       wbits;
	assign exp_mem  = acc_write ? mir[acc_idx][WRITE_TO_MEMORY_BIT] : mir[acc_idx][READ_TO_MEMORY_BIT];
	assign exp_type = mir[acc_idx][2:0];
	assign exp_rd   = cfg_rdata[CFG_MOD_BIT] ? mir[fld_idx] : {2'b00, mir[fld_idx][2:0]};
	assign wbits    = cfg_wdata[CFG_MOD_BIT:CFG_ATTR_BIT];
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mir <= '{default: FLD_RESET};
		end else if (fld_wr) begin
			mir[fld_idx][2:0] <= fld_wdata[2:0];
			if (cfg_rdata[CFG_MOD_BIT]) begin
				mir[fld_idx][4:3] <= fld_wdata[4:3];
			end
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_acc_on;  acc_valid && cfg_rdata[CFG_ATTR_BIT];  endsequence
	sequence s_acc_off; acc_valid && !cfg_rdata[CFG_ATTR_BIT]; endsequence
	property p_acc_rsp; acc_valid |=> rsp_valid; endproperty
	property p_rd_rsp; fld_rd |=> fld_rvalid; endproperty
	property p_route; s_acc_on |=> rsp_to_mem == $past(exp_mem); endproperty
	property p_type; acc_valid |=> rsp_type == $past(exp_type); endproperty
	property p_off_io; s_acc_off |=> !rsp_to_mem && !rsp_reserved; endproperty
	property p_readback; fld_rd |=> fld_rdata == $past(exp_rd); endproperty
	property p_cfg_hold; !cfg_wr |=> $stable(cfg_rdata); endproperty
	property p_cfg_bits; cfg_wr |=> cfg_rdata[19:18] == $past(wbits); endproperty
	a_acc_rsp: assert property (p_acc_rsp)
		else $error("no response one cycle after access");
	a_rd_rsp: assert property (p_rd_rsp)
		else $error("no field read answer");
	a_route: assert property (p_route)
		else $error("access routed against its routing bit");
	a_type: assert property (p_type)
		else $error("response type differs from low field bits");
	a_off_io: assert property (p_off_io)
		else $error("disabled routing did not go to I/O");
	a_readback: assert property (p_readback)
		else $error("field read value wrong");
	a_cfg_hold: assert property (p_cfg_hold)
		else $error("configuration changed without a write");
	a_cfg_bits: assert property (p_cfg_bits)
		else $error("enable bits not taken from write");
endmodule : frr_link_assertions
`default_nettype wire

/* File: test_fixed_range_mem_io_routing.sv */
// Testbench for controller and routing unit joined by the link
`default_nettype none
module test_fixed_range_mem_io_routing
	import frr_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [31:0] paddr = 0, pwdata = 0, prdata;
	logic        pready, pslverr, page_present, tlb_flush_req, cache_flush_req;
	logic        tlb_flush_ack = 0, cache_flush_ack = 0, tlb_done = 0;
	logic        mem_rd, mem_wr, mmio_rd, mmio_wr, route_reserved, attr_en, mod_en;
	logic [2:0]  route_type;
	int          failures = 0, n_compared = 0, n_cache = 0, n_tlb = 0, n_mem = 0, n_bad = 0;
	int          n_io = 0;
	logic [4:0]  fv [8] = '{5'h00, 5'h01, 5'h08, 5'h10, 5'h15, 5'h1e, 5'h1c, 5'h19};
	logic [4:0]  bad [5] = '{5'h06, 5'h09, 5'h11, 5'h1d, 5'h02};
	frr_link_if lnk ();
	frr_router i_frr_router (.pclk(pclk), .presetn(presetn), .lnk(lnk), .mem_rd(mem_rd),
		.mem_wr(mem_wr), .mmio_rd(mmio_rd), .mmio_wr(mmio_wr), .route_type(route_type),
		.route_reserved(route_reserved), .attr_en(attr_en), .mod_en(mod_en));
	frr_ctrl i_frr_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .page_present(page_present), .tlb_flush_req(tlb_flush_req),
		.tlb_flush_ack(tlb_flush_ack), .cache_flush_req(cache_flush_req),
		.cache_flush_ack(cache_flush_ack), .lnk(lnk));
	frr_link_assertions i_chk (.pclk(pclk), .presetn(presetn), .cfg_wr(lnk.cfg_wr),
		.cfg_wdata(lnk.cfg_wdata), .cfg_rdata(lnk.cfg_rdata), .fld_wr(lnk.fld_wr),
		.fld_rd(lnk.fld_rd), .fld_idx(lnk.fld_idx), .fld_wdata(lnk.fld_wdata),
		.fld_rvalid(lnk.fld_rvalid), .fld_rdata(lnk.fld_rdata), .acc_valid(lnk.acc_valid),
		.acc_idx(lnk.acc_idx), .acc_write(lnk.acc_write), .rsp_valid(lnk.rsp_valid),
		.rsp_to_mem(lnk.rsp_to_mem), .rsp_type(lnk.rsp_type), .rsp_reserved(lnk.rsp_reserved));
	always #5 pclk = ~pclk;
	// Flush acknowledger, one cycle after each request; also watches ordering
	always @(posedge pclk) begin
		tlb_flush_ack <= tlb_flush_req && !tlb_flush_ack;
		cache_flush_ack <= cache_flush_req && !cache_flush_ack;
		if (tlb_flush_req && tlb_flush_ack) begin
			n_tlb <= n_tlb + 1;
			tlb_done <= 1'b1;
		end else if (tlb_flush_req) begin
			// Each change must finish its own TLB flush before a cache flush
			tlb_done <= 1'b0;
		end
		if (cache_flush_req && cache_flush_ack) n_cache <= n_cache + 1;
		if ((cache_flush_req && !tlb_done) || (tlb_flush_req && page_present)) n_bad <= n_bad + 1;
		if (mem_rd || mem_wr) n_mem <= n_mem + 1;
		if (mmio_rd || mmio_wr) n_io <= n_io + 1;
	end
	task automatic stop_test();
		$display("compared %0d, mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : stop_test
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	// One APB transfer; entered just after a rising edge
	task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d,
			output logic [31:0] q, output logic e);
		int n;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 100);
		q = prdata;
		e = pslverr;
		if (n >= 100) begin
			failures++;
			stop_test();
		end else begin
			psel <= 1'b0;
			penable <= 1'b0;
			@(posedge pclk);
		end
	endtask : apb
	task automatic rd(input logic [11:0] a, output logic [31:0] q);
		logic e;
		apb(1'b0, {20'h0, a}, 32'h0, q, e);
	endtask : rd
	// Issue a command and wait until the controller is idle again
	task automatic cmd(input logic [3:0] op, input int idx, input logic [4:0] v,
			input logic w, output logic [31:0] st);
		logic [31:0] c;
		logic        e;
		int          n;
		c = 32'h0;
		c[3:0] = op;
		c[10:8] = idx[2:0];
		c[20:16] = v;
		c[24] = w;
		apb(1'b1, {20'h0, REG_CMD}, c, st, e);
		n = 0;
		do begin
			rd(REG_STATUS, st);
			n++;
		end while (st[ST_BUSY] !== 1'b0 && n < 50);
		if (n >= 50) begin
			failures++;
			stop_test();
		end
	endtask : cmd
	task automatic t_reset();
		logic [31:0] q;
		logic        e;
		rd(REG_STATUS, q);
		check(q, 32'h10);
		check({31'h0, attr_en | mod_en}, 32'h0);
		apb(1'b0, 32'h00c, 32'h0, q, e);
		check({q[30:0], e}, 32'h1);
		$display("test reset done");
	endtask : t_reset
	task automatic t_order();
		logic [31:0] st;
		cmd(OP_SET_FIELD, 1, 5'h01, 1'b0, st);
		check(st[1:0], 2'h2);
		cmd(OP_MOD_ON, 0, 5'h0, 1'b0, st);
		check({31'h0, mod_en}, 32'h1);
		cmd(OP_ENABLE, 0, 5'h0, 1'b0, st);
		check(st[6:5] & 2'h2, 2'h0);
		for (int i = 0; i < 5; i++) begin
			cmd(OP_SET_FIELD, i, bad[i], 1'b0, st);
			check(st[1], 1'b1);
		end
		cmd(4'h0, 0, 5'h0, 1'b0, st);
		check(st[1], 1'b1);
		$display("test order done");
	endtask : t_order
	task automatic t_route();
		logic [31:0] st, q;
		int          m;
		int          k;
		for (int i = 0; i < 8; i++) cmd(OP_SET_FIELD, i, fv[i], 1'b0, st);
		cmd(OP_ACCESS, 5, 5'h0, 1'b1, st);
		check(st[3:1], 3'h0);
		cmd(OP_ENABLE, 0, 5'h0, 1'b0, st);
		check(st[6:4], 3'h7);
		m = n_mem;
		k = n_io;
		for (int i = 0; i < 16; i++) begin
			cmd(OP_ACCESS, i / 2, 5'h0, i[0], st);
			check(st[3:2], {1'b0, fv[i/2][i[0] ? 3 : 4]});
			check({29'h0, route_type}, {29'h0, fv[i/2][2:0]});
			check({31'h0, route_reserved}, 32'h0);
			rd(REG_DATA, q);
			check(q, {29'h0, fv[i/2][2:0]});
			if (fv[i/2][i[0] ? 3 : 4]) m++;
			else k++;
		end
		check(n_mem, m);
		check(n_io, k);
		$display("test route done");
	endtask : t_route
	task automatic t_modoff();
		logic [31:0] st, q;
		cmd(OP_MOD_OFF, 0, 5'h0, 1'b0, st);
		cmd(OP_READ, 5, 5'h0, 1'b0, st);
		rd(REG_DATA, q);
		check(q, 32'h06);
		cmd(OP_MOD_ON, 0, 5'h0, 1'b0, st);
		cmd(OP_READ, 5, 5'h0, 1'b0, st);
		rd(REG_DATA, q);
		check(q, 32'h1e);
		$display("test modify enable done");
	endtask : t_modoff
	task automatic t_shadow();
		logic [31:0] st;
		cmd(OP_SHADOW_CPY, 1, 5'h0, 1'b0, st);
		cmd(OP_ACCESS, 1, 5'h0, 1'b1, st);
		check(st[3:2], 2'h1);
		cmd(OP_ACCESS, 1, 5'h0, 1'b0, st);
		check(st[3:2], 2'h0);
		cmd(OP_SHADOW_USE, 1, 5'h0, 1'b0, st);
		cmd(OP_ACCESS, 1, 5'h0, 1'b0, st);
		check(st[3:2], 2'h1);
		cmd(OP_ACCESS, 1, 5'h0, 1'b1, st);
		check(st[3:2], 2'h0);
		$display("test shadow done");
	endtask : t_shadow
	task automatic t_change();
		logic [31:0] st, q;
		logic        e;
		cmd(OP_CHANGE, 5, 5'h00, 1'b0, st);
		check(n_tlb, 1);
		check(n_cache, 1);
		cmd(OP_READ, 5, 5'h0, 1'b0, st);
		rd(REG_DATA, q);
		check(q, 32'h18);
		// Second change to write-combining, then a command while it still runs
		apb(1'b1, {20'h0, REG_CMD}, 32'h0001_0509, q, e);
		apb(1'b1, {20'h0, REG_CMD}, 32'h0000_0006, q, e);
		check({31'h0, e}, 32'h1);
		cmd(OP_READ, 5, 5'h0, 1'b0, st);
		rd(REG_DATA, q);
		check(q, 32'h19);
		check(n_tlb, 2);
		check(n_cache, 1);
		check(st[4], 1'b1);
		check(n_bad, 0);
		$display("test change done");
	endtask : t_change
	// Reset again in mid-run: field 5 and both enables must clear
	task automatic t_rearm();
		logic [31:0] st, q;
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(REG_STATUS, q);
		check(q, 32'h10);
		cmd(OP_MOD_ON, 0, 5'h0, 1'b0, st);
		cmd(OP_READ, 5, 5'h0, 1'b0, st);
		rd(REG_DATA, q);
		check(q, 32'h00);
		cmd(OP_ACCESS, 5, 5'h0, 1'b0, st);
		check(st[3:2], 2'h0);
		$display("test reset again done");
	endtask : t_rearm
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		t_order();
		t_route();
		t_modoff();
		t_shadow();
		t_change();
		t_rearm();
		stop_test();
	end
	initial begin
		#200000;
		failures++;
		stop_test();
	end
endmodule : test_fixed_range_mem_io_routing
`default_nettype wire
